// File: hw/ebu_pkg.sv
// Constants, field layout and types of the external bus unit.
// Assumes a single clock domain and an APB register slave with 32-bit data.
package ebu_pkg;
	localparam int ADDR_W   = 24;
	localparam int DATA_W   = 16;
	localparam int NUM_WIN  = 4;
	localparam int SYNC_LAT = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_SYSCFG = 8'h00;
	localparam logic [7:0] OFS_PINDIR = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_BUSCFG = 8'h10;
	localparam logic [7:0] OFS_RANGE  = 8'h30;

	// system_config_register fields
	localparam int SC_EXT     = 0;
	localparam int SC_ARB     = 1;
	localparam int SC_SEG_LSB = 2;
	localparam logic [3:0] SYSCFG_RST = 4'h1;

	// window_bus_config fields
	localparam int BC_WAIT_LSB = 0;
	localparam int BC_TRI      = 4;
	localparam int BC_ALE      = 5;
	localparam int BC_RWD      = 6;
	localparam int BC_RDY      = 7;
	localparam int BC_MODE_LSB = 8;
	localparam int BC_EN       = 10;
	localparam int BC_CS       = 11;
	localparam logic [11:0] BUSCFG0_RST = 12'hcff;
	localparam logic [11:0] BUSCFG_RST  = 12'h000;

	// window_range_select fields: base = A23..A12, size code gives 4 KB << size
	localparam int RS_SIZE_LSB = 12;
	localparam logic [15:0] RANGE_RST = 16'h0000;

	typedef enum logic [1:0] {
		EBU_MODE_D16 = 2'b00,
		EBU_MODE_M16 = 2'b01,
		EBU_MODE_M8  = 2'b10,
		EBU_MODE_D8  = 2'b11
	} ebu_mode_t;

	typedef enum logic [2:0] {
		EBU_IDLE  = 3'b000,
		EBU_ADDR  = 3'b001,
		EBU_SETUP = 3'b010,
		EBU_STRB  = 3'b011,
		EBU_RECOV = 3'b100,
		EBU_HELD  = 3'b101,
		EBU_ACQ   = 3'b110
	} ebu_state_t;
endpackage

// File: hw/ebu_top.sv
// External bus unit: carries CPU requests to the off-chip parallel bus, APB registers.
// Assumes all pin inputs are asynchronous; CPU request port and APB share i_mclk.
// Function
// - Single-chip setting plus 8/16-bit, multiplexed or demultiplexed external modes.
// - Demultiplexed: address on dedicated port, data on shared port or its low byte.
// - Multiplexed: shared port carries address first, then data.
// - Cycle length, tri-state recovery, latch strobe length, read/write delay programmable.
// - Four address windows, each with range-select and bus-config registers.
// - Window four beats three, window two beats one on overlap.
// - Addresses outside all windows use default bus config zero.
// - Five chip selects: one per window plus default region.
// - Ready input lets slow devices stretch an access.
// - Arbitration stays inactive until the arbitration enable bit is set.
// - When enabled, request, acknowledge and hold pins are run automatically.
// - After reset the unit is arbitration master, acknowledge pin an output.
// - With arbitration enabled, direction bit one selects slave role, acknowledge pin becomes input.
// - Segment port outputs eight, four, two or no upper address lines.
// - Linear external space up to 16 MBytes.
// - Dedicated port keeps the address after switching demultiplexed to multiplexed.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module ebu_top
	import ebu_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [7:0]        i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic              i_req,
	input  wire logic              i_req_wr,
	input  wire logic [ADDR_W-1:0] i_req_addr,
	input  wire logic [DATA_W-1:0] i_req_wdata,
	output logic                   o_ack,
	output logic                   o_err,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic [DATA_W-1:0] i_data_in,
	output logic      [DATA_W-1:0] o_data_out,
	output logic      [DATA_W-1:0] o_data_oe_n,
	output logic      [15:0]       o_addr_out,
	output logic                   o_addr_oe_n,
	output logic      [7:0]        o_seg_out,
	output logic      [7:0]        o_seg_oe_n,
	output logic                   o_ale,
	output logic                   o_rd_n,
	output logic                   o_wr_n,
	output logic      [NUM_WIN:0]  o_cs_n,
	input  wire logic              i_ready_n,
	input  wire logic              i_hold_n,
	input  wire logic              i_bus_release_acknowledge_n,
	output logic                   o_bus_release_acknowledge_n,
	output logic                   o_bus_release_acknowledge_oe_n,
	output logic                   o_bus_need_request_out_n
);
	// Window hit: base compared above the window size, size code 0..12 gives 4 KB .. 16 MB
	function automatic logic win_hit(input logic [ADDR_W-1:0] a, input logic [15:0] rs);
		logic [11:0] msk;
		msk = 12'hfff << rs[RS_SIZE_LSB +: 4];
		win_hit = ((a[23:12] ^ rs[11:0]) & msk) == 12'h000;
	endfunction

	logic [3:0]        syscfg_r,  syscfg_nxt;
	logic              pindir_r,  pindir_nxt;
	logic [11:0]       buscfg_r   [NUM_WIN+1];
	logic [11:0]       buscfg_nxt [NUM_WIN+1];
	logic [15:0]       range_r    [1:NUM_WIN];
	logic [15:0]       range_nxt  [1:NUM_WIN];
	logic [31:0]       prdata_nxt;
	logic              pready_nxt, pslverr_nxt;
	logic [2:0]        rdy_s, hold_s, bus_release_acknowledge_s;
	logic [DATA_W-1:0] din_m, din_s;

	ebu_state_t        state_r, state_nxt;
	logic [4:0]        cnt_r, cnt_nxt;
	logic [ADDR_W-1:0] cyc_addr_r, cyc_addr_nxt;
	logic [DATA_W-1:0] cyc_wdata_r, cyc_wdata_nxt;
	logic              cyc_wr_r, cyc_wr_nxt;
	logic [11:0]       cfg_r, cfg_nxt;
	logic [2:0]        win_r, win_nxt;
	logic              demux_seen_r, demux_seen_nxt;
	logic              ack_nxt, err_nxt;
	logic [DATA_W-1:0] rdata_nxt, dout_nxt, doe_nxt;
	logic [15:0]       aout_nxt;
	logic              aoe_nxt, ale_nxt, rd_nxt, wr_nxt, bus_release_acknowledge_nxt, bus_need_request_out_nxt;
	logic [7:0]        seg_nxt, segoe_nxt;
	logic [NUM_WIN:0]  cs_nxt;

	// Address decode; window 4 over 3 over 2 over 1, default region otherwise
	logic [2:0]  sel_win;
	logic [11:0] sel_cfg;
	always_comb
	begin
		sel_win = 3'd0;
		for (int i = 1; i <= NUM_WIN; i++)
			if (buscfg_r[i][BC_EN] && win_hit(i_req_addr, range_r[i]))
				sel_win = 3'(i);
		sel_cfg = buscfg_r[sel_win];
	end

	// APB register slave: answer in the second access cycle
	logic       apb_acc, apb_wr_do, apb_bad, bc_hit, rs_hit;
	logic [7:0] bc_off, rs_off;
	always_comb
	begin
		apb_acc   = i_psel && i_penable && !o_pready;
		apb_wr_do = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
		// Offsets relative to each block, so five config words may cross a 16-byte boundary
		bc_off    = i_paddr - OFS_BUSCFG;
		rs_off    = i_paddr - OFS_RANGE;
		bc_hit    = bc_off[7:2] <= 6'(NUM_WIN);
		rs_hit    = rs_off[7:2] < 6'(NUM_WIN);
		apb_bad   = 1'b0;
		prdata_nxt = 32'h0000_0000;
		if (i_paddr == OFS_SYSCFG)
			prdata_nxt = {28'h0000000, syscfg_r};
		else if (i_paddr == OFS_PINDIR)
			prdata_nxt = {31'h00000000, pindir_r};
		else if (i_paddr == OFS_STATUS)
			prdata_nxt = {25'h0000000, demux_seen_r, o_bus_release_acknowledge_n, o_bus_need_request_out_n, win_r, state_r == EBU_HELD};
		else if (bc_hit)
			prdata_nxt = {20'h00000, buscfg_r[bc_off[4:2]]};
		else if (rs_hit)
			prdata_nxt = {16'h0000, range_r[3'(rs_off[3:2]) + 3'd1]};
		else
			apb_bad = 1'b1;
		if (i_paddr[1:0] != 2'b00)
			apb_bad = 1'b1;
		if (apb_bad)
			prdata_nxt = 32'h0000_0000;
		pready_nxt  = apb_acc;
		pslverr_nxt = apb_acc && apb_bad;
		if (!apb_acc)
			prdata_nxt = o_prdata;

		syscfg_nxt = syscfg_r;
		pindir_nxt = pindir_r;
		buscfg_nxt = buscfg_r;
		range_nxt  = range_r;
		if (apb_wr_do)
		begin
			if (i_paddr == OFS_SYSCFG)
				syscfg_nxt = {i_pwdata[3:2], syscfg_r[SC_ARB] | i_pwdata[SC_ARB], i_pwdata[SC_EXT]};
			else if (i_paddr == OFS_PINDIR)
				pindir_nxt = i_pwdata[0];
			else if (bc_hit)
				buscfg_nxt[bc_off[4:2]] = i_pwdata[11:0];
			else if (rs_hit)
				range_nxt[3'(rs_off[3:2]) + 3'd1] = i_pwdata[15:0];
		end
	end

	// Bus cycle sequencer
	logic arb_on, slave, held_req, go, cyc_mux, cyc_b8, rdy_en;
	always_comb
	begin
		arb_on   = syscfg_r[SC_ARB];
		slave    = pindir_r;
		held_req = arb_on && !slave && !hold_s[2];
		cyc_mux  = cfg_r[BC_MODE_LSB +: 2] == EBU_MODE_M16 || cfg_r[BC_MODE_LSB +: 2] == EBU_MODE_M8;
		cyc_b8   = cfg_r[BC_MODE_LSB +: 2] == EBU_MODE_M8 || cfg_r[BC_MODE_LSB +: 2] == EBU_MODE_D8;
		rdy_en   = cfg_r[BC_RDY];
		go       = 1'b0;
		state_nxt      = state_r;
		cnt_nxt        = cnt_r;
		cyc_addr_nxt   = cyc_addr_r;
		cyc_wdata_nxt  = cyc_wdata_r;
		cyc_wr_nxt     = cyc_wr_r;
		cfg_nxt        = cfg_r;
		win_nxt        = win_r;
		demux_seen_nxt = demux_seen_r;
		ack_nxt   = 1'b0;
		err_nxt   = 1'b0;
		rdata_nxt = o_rdata;
		dout_nxt  = o_data_out;
		doe_nxt   = {DATA_W{1'b1}};
		aout_nxt  = o_addr_out;
		aoe_nxt   = o_addr_oe_n;
		ale_nxt   = 1'b0;
		rd_nxt    = 1'b1;
		wr_nxt    = 1'b1;
		cs_nxt    = o_cs_n;
		seg_nxt   = o_seg_out;
		segoe_nxt = o_seg_oe_n;
		bus_release_acknowledge_nxt  = 1'b1;
		bus_need_request_out_nxt  = 1'b1;
		case (state_r)
			EBU_IDLE:
			begin
				cs_nxt = '1;
				if (held_req)
					state_nxt = EBU_HELD;
				else if (i_req && !o_ack)
				begin
					if (!syscfg_r[SC_EXT])
					begin
						ack_nxt = 1'b1;
						err_nxt = 1'b1;
					end
					else if (arb_on && slave)
					begin
						bus_need_request_out_nxt  = 1'b0;
						state_nxt = EBU_ACQ;
					end
					else
						go = 1'b1;
				end
			end
			EBU_ACQ:
			begin
				bus_need_request_out_nxt = 1'b0;
				if (!bus_release_acknowledge_s[2])
					go = 1'b1;
			end
			EBU_ADDR:
			begin
				if (slave && arb_on)
					bus_need_request_out_nxt = 1'b0;
				if (cnt_r != 5'd0)
				begin
					ale_nxt = 1'b1;
					doe_nxt = cyc_mux ? 16'h0000 : 16'hffff;
					cnt_nxt = cnt_r - 5'd1;
				end
				else
				begin
					cnt_nxt = 5'(cfg_r[BC_WAIT_LSB +: 4]) + (cyc_wr_r ? 5'd0 : 5'(SYNC_LAT));
					state_nxt = cfg_r[BC_RWD] ? EBU_SETUP : EBU_STRB;
					if (cyc_mux)
						doe_nxt = cyc_b8 ? 16'h00ff : 16'hffff;
				end
			end
			EBU_SETUP:
			begin
				if (slave && arb_on)
					bus_need_request_out_nxt = 1'b0;
				state_nxt = EBU_STRB;
			end
			EBU_STRB:
			begin
				if (slave && arb_on)
					bus_need_request_out_nxt = 1'b0;
				if (cnt_r != 5'd0)
					cnt_nxt = cnt_r - 5'd1;
				else if (!rdy_en || !rdy_s[2])
				begin
					ack_nxt   = 1'b1;
					rdata_nxt = cyc_b8 ? {8'h00, din_s[7:0]} : din_s;
					state_nxt = (cfg_r[BC_TRI] && !cyc_wr_r) ? EBU_RECOV : EBU_IDLE;
					if (state_nxt == EBU_IDLE)
						cs_nxt = '1;
				end
			end
			EBU_RECOV:
			begin
				cs_nxt    = '1;
				state_nxt = EBU_IDLE;
			end
			EBU_HELD:
			begin
				cs_nxt    = '1;
				aoe_nxt   = 1'b1;
				segoe_nxt = 8'hff;
				seg_nxt   = 8'h00;
				bus_release_acknowledge_nxt  = 1'b0;
				rd_nxt    = 1'b1;
				if (i_req && !o_ack)
					bus_need_request_out_nxt = 1'b0;
				if (hold_s[2])
				begin
					bus_release_acknowledge_nxt  = 1'b1;
					state_nxt = EBU_IDLE;
				end
			end
			default:
				state_nxt = EBU_IDLE;
		endcase

		// Strobe and data drive are decided a cycle ahead, so the pins stay registered
		if (state_nxt == EBU_STRB)
		begin
			rd_nxt = cyc_wr_r;
			wr_nxt = !cyc_wr_r;
			if (cyc_wr_r)
			begin
				dout_nxt = cyc_b8 ? {cyc_addr_r[15:8], cyc_wdata_r[7:0]} : cyc_wdata_r;
				doe_nxt  = cyc_b8 ? (cyc_mux ? 16'h0000 : 16'hff00) : 16'h0000;
			end
			else if (cyc_mux && cyc_b8)
				doe_nxt = 16'h00ff;
		end

		if (go)
		begin
			cyc_addr_nxt  = i_req_addr;
			cyc_wdata_nxt = i_req_wdata;
			cyc_wr_nxt    = i_req_wr;
			cfg_nxt       = sel_cfg;
			win_nxt       = sel_win;
			cnt_nxt       = sel_cfg[BC_ALE] ? 5'd1 : 5'd0;
			ale_nxt       = 1'b1;
			if (sel_cfg[BC_MODE_LSB +: 2] == EBU_MODE_M16 || sel_cfg[BC_MODE_LSB +: 2] == EBU_MODE_M8)
				doe_nxt = 16'h0000;
			state_nxt     = EBU_ADDR;
			cs_nxt        = '1;
			if (sel_cfg[BC_CS])
				cs_nxt[sel_win] = 1'b0;
			if (sel_cfg[BC_MODE_LSB +: 2] == EBU_MODE_D16 || sel_cfg[BC_MODE_LSB +: 2] == EBU_MODE_D8)
				demux_seen_nxt = 1'b1;
			aout_nxt = i_req_addr[15:0];
			aoe_nxt  = !(demux_seen_nxt || sel_cfg[BC_MODE_LSB] == 1'b0 && !sel_cfg[BC_MODE_LSB+1] ||
			             sel_cfg[BC_MODE_LSB +: 2] == EBU_MODE_D8);
			dout_nxt = i_req_addr[15:0];
			case (syscfg_r[SC_SEG_LSB +: 2])
				2'b00:   segoe_nxt = 8'h00;
				2'b01:   segoe_nxt = 8'hf0;
				2'b10:   segoe_nxt = 8'hfc;
				default: segoe_nxt = 8'hff;
			endcase
			seg_nxt = i_req_addr[23:16] & ~segoe_nxt;
		end
	end

	// Ready, hold and acknowledge pins pass three flip-flops before use, data inputs two
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			rdy_s  <= 3'b111;
			hold_s <= 3'b111;
			bus_release_acknowledge_s <= 3'b111;
			din_m  <= 16'h0000;
			din_s  <= 16'h0000;
		end
		else if (i_ce)
		begin
			rdy_s  <= {rdy_s[1], rdy_s[0], i_ready_n};
			hold_s <= {hold_s[1], hold_s[0], i_hold_n};
			bus_release_acknowledge_s <= {bus_release_acknowledge_s[1], bus_release_acknowledge_s[0], i_bus_release_acknowledge_n};
			din_m  <= i_data_in;
			din_s  <= din_m;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			syscfg_r  <= SYSCFG_RST;
			pindir_r  <= 1'b0;
			buscfg_r[0] <= BUSCFG0_RST;
			for (int i = 1; i <= NUM_WIN; i++)
			begin
				buscfg_r[i] <= BUSCFG_RST;
				range_r[i]  <= RANGE_RST;
			end
			o_prdata  <= 32'h0000_0000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			state_r      <= EBU_IDLE;
			cnt_r        <= 5'h00;
			cyc_addr_r   <= 24'h000000;
			cyc_wdata_r  <= 16'h0000;
			cyc_wr_r     <= 1'b0;
			cfg_r        <= BUSCFG0_RST;
			win_r        <= 3'h0;
			demux_seen_r <= 1'b0;
			o_ack        <= 1'b0;
			o_err        <= 1'b0;
			o_rdata      <= 16'h0000;
			o_data_out   <= 16'h0000;
			o_data_oe_n  <= 16'hffff;
			o_addr_out   <= 16'h0000;
			o_addr_oe_n  <= 1'b1;
			o_seg_out    <= 8'h00;
			o_seg_oe_n   <= 8'hff;
			o_ale        <= 1'b0;
			o_rd_n       <= 1'b1;
			o_wr_n       <= 1'b1;
			o_cs_n       <= '1;
			o_bus_release_acknowledge_n     <= 1'b1;
			o_bus_release_acknowledge_oe_n  <= 1'b0;
			o_bus_need_request_out_n     <= 1'b1;
		end
		else if (i_ce)
		begin
			syscfg_r  <= syscfg_nxt;
			pindir_r  <= pindir_nxt;
			buscfg_r  <= buscfg_nxt;
			range_r   <= range_nxt;
			o_prdata  <= prdata_nxt;
			o_pready  <= pready_nxt;
			o_pslverr <= pslverr_nxt;
			state_r      <= state_nxt;
			cnt_r        <= cnt_nxt;
			cyc_addr_r   <= cyc_addr_nxt;
			cyc_wdata_r  <= cyc_wdata_nxt;
			cyc_wr_r     <= cyc_wr_nxt;
			cfg_r        <= cfg_nxt;
			win_r        <= win_nxt;
			demux_seen_r <= demux_seen_nxt;
			o_ack        <= ack_nxt;
			o_err        <= err_nxt;
			o_rdata      <= rdata_nxt;
			o_data_out   <= dout_nxt;
			o_data_oe_n  <= doe_nxt;
			o_addr_out   <= aout_nxt;
			o_addr_oe_n  <= aoe_nxt;
			o_seg_out    <= seg_nxt;
			o_seg_oe_n   <= segoe_nxt;
			o_ale        <= ale_nxt;
			o_rd_n       <= rd_nxt;
			o_wr_n       <= wr_nxt;
			o_cs_n       <= cs_nxt;
			o_bus_release_acknowledge_n     <= bus_release_acknowledge_nxt || !arb_on || slave;
			o_bus_release_acknowledge_oe_n  <= arb_on && slave;
			o_bus_need_request_out_n     <= bus_need_request_out_nxt || !arb_on;
		end
	end
endmodule

// File: tb/ebu_props.sv
// Checker for the external bus unit, bound to the top module ports.
// Assumes i_ce held high; one clock domain, synchronous active-low reset.
`timescale 1ns/1ps
module ebu_props
	import ebu_pkg::*;
(
	input wire logic              i_mclk,
	input wire logic              i_rst_n,
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [7:0]        i_paddr,
	input wire logic [31:0]       i_pwdata,
	input wire logic              o_pready,
	input wire logic [DATA_W-1:0] o_data_oe_n,
	input wire logic              o_addr_oe_n,
	input wire logic [7:0]        o_seg_out,
	input wire logic [7:0]        o_seg_oe_n,
	input wire logic              o_rd_n,
	input wire logic              o_wr_n,
	input wire logic              i_hold_n,
	input wire logic              o_bus_release_acknowledge_n,
	input wire logic              o_bus_release_acknowledge_oe_n,
	input wire logic              o_bus_need_request_out_n
);
	logic arb_r;
	logic arb_nxt;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Arbitration is sticky, so the shadow only ever sets
	always_comb arb_nxt = arb_r | (i_psel & i_penable & o_pready & i_pwrite & (i_paddr == OFS_SYSCFG) & i_pwdata[SC_ARB]);
	always_ff @(posedge i_mclk) arb_r <= i_rst_n ? arb_nxt : 1'b0;
	chk_reset_role: assert property ($rose(i_rst_n) |-> !o_bus_release_acknowledge_oe_n && o_bus_release_acknowledge_n && o_bus_need_request_out_n)
		else $error("acknowledge pin not a master output after reset");
	chk_strobe_excl: assert property (o_rd_n || o_wr_n)
		else $error("read and write strobes active together");
	chk_write_drive: assert property (!o_wr_n |-> o_data_oe_n[7:0] == 8'h00)
		else $error("data lines not driven during write strobe");
	chk_read_float: assert property (!o_rd_n |-> &o_data_oe_n[7:0])
		else $error("data lines driven during read strobe");
	chk_held_float: assert property (!o_bus_release_acknowledge_n && !o_bus_release_acknowledge_oe_n |-> &o_data_oe_n && o_addr_oe_n && &o_seg_oe_n)
		else $error("bus outputs driven while hold acknowledged");
	chk_hold_release: assert property (!o_bus_release_acknowledge_oe_n && !o_bus_release_acknowledge_n && $rose(i_hold_n) |-> ##[1:4] o_bus_release_acknowledge_n)
		else $error("hold acknowledge kept after request withdrawn");
	chk_arb_off: assert property (!arb_r |-> o_bus_release_acknowledge_n && o_bus_need_request_out_n)
		else $error("arbitration pins active before enable");
	chk_seg_mask: assert property ((o_seg_out & o_seg_oe_n) == 8'h00)
		else $error("unused segment line carries a value");
endmodule
bind ebu_top ebu_props chk_u (.*);

// File: tb/ebu_mem_model.sv
// External memory on the far side of the bus, with a stretchable ready.
// Assumes registered strobes; i_slow sets the ready delay in cycles.
`timescale 1ns/1ps
module ebu_mem_model
	import ebu_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic [DATA_W-1:0] i_data_out,
	input  wire logic [DATA_W-1:0] i_data_oe_n,
	input  wire logic [15:0]       i_addr_out,
	input  wire logic [7:0]        i_seg_oe_n,
	input  wire logic              i_ale,
	input  wire logic              i_rd_n,
	input  wire logic              i_wr_n,
	input  wire logic [NUM_WIN:0]  i_cs_n,
	input  wire logic [3:0]        i_slow,
	output logic      [DATA_W-1:0] o_data_in,
	output logic                   o_ready_n
);
	logic [DATA_W-1:0] mem [256];
	logic [15:0]       addr_r;
	logic [NUM_WIN:0]  cs_r;
	logic [7:0]        seg_r;
	logic [3:0]        cnt_r = 4'h0;
	logic [DATA_W-1:0] last_r = '0;
	always @(posedge i_mclk)
	begin
		if (i_ale)
		begin
			addr_r <= i_data_oe_n[0] ? i_addr_out : i_data_out;
			cs_r <= i_cs_n;
			seg_r <= i_seg_oe_n;
		end
		cnt_r <= (i_rd_n && i_wr_n) ? 4'h0 : cnt_r + 4'h1;
		if (!i_wr_n)
			mem[addr_r[7:0]] <= i_data_out;
		last_r <= o_data_in;
	end
	// Released lines toggle so a stale value can never pass as read data
	assign o_data_in = !i_rd_n ? mem[addr_r[7:0]] : ~last_r;
	assign o_ready_n = (i_rd_n && i_wr_n) || (cnt_r < i_slow);
endmodule

// File: tb/tb_top.sv
// Bench for the external bus unit: APB and CPU request tasks.
// Assumes a 250 MHz clock and the memory model on the pin side.
`timescale 1ns/1ps
module tb_top;
	import ebu_pkg::*;
	logic              i_mclk = 1'b0;
	logic              i_ce = 1'b1;
	logic              i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]        i_paddr = '0;
	logic [31:0]       i_pwdata = '0, o_prdata;
	logic              i_req = 1'b0, i_req_wr = 1'b0, i_hold_n = 1'b1, bus_release_acknowledge_ext = 1'b1;
	logic [ADDR_W-1:0] i_req_addr = '0;
	logic [DATA_W-1:0] i_req_wdata = '0, o_rdata, i_data_in, o_data_out, o_data_oe_n, mdin, q;
	logic              o_pready, o_pslverr, o_ack, o_err, o_addr_oe_n, o_ale, o_rd_n, o_wr_n;
	logic              i_ready_n, i_bus_release_acknowledge_n, o_bus_release_acknowledge_n, o_bus_release_acknowledge_oe_n, o_bus_need_request_out_n, err_q;
	logic [15:0]       o_addr_out;
	logic [7:0]        o_seg_out, o_seg_oe_n;
	logic [NUM_WIN:0]  o_cs_n;
	logic [3:0]        slow = 4'h0;
	logic [7:0]        segx [4] = '{8'h00, 8'hf0, 8'hfc, 8'hff};
	int                errors = 0, tests_run = 0, cyc = 0, t0, t1;
	ebu_top dut_u (.*);
	ebu_mem_model m (.i_mclk(i_mclk), .i_data_out(o_data_out), .i_data_oe_n(o_data_oe_n),
		.i_addr_out(o_addr_out), .i_seg_oe_n(o_seg_oe_n), .i_ale(o_ale), .i_rd_n(o_rd_n),
		.i_wr_n(o_wr_n), .i_cs_n(o_cs_n), .i_slow(slow), .o_data_in(mdin), .o_ready_n(i_ready_n));
	// Each lane resolves from its own enable
	assign i_data_in = (o_data_out & ~o_data_oe_n) | (mdin & o_data_oe_n);
	assign i_bus_release_acknowledge_n = o_bus_release_acknowledge_oe_n ? bus_release_acknowledge_ext : o_bus_release_acknowledge_n;
	initial forever #2 i_mclk = ~i_mclk;
	task automatic wrap_up();
		if (errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic e);
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do
			@(negedge i_mclk);
		while (o_pready !== 1'b1);
		cmp(o_pslverr, e);
		if (!w)
			cmp(o_prdata, x);
		@(posedge i_mclk);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic cpu(input logic w, input logic [23:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_req <= 1'b1;
		i_req_wr <= w;
		i_req_addr <= a;
		i_req_wdata <= d;
		do
			@(negedge i_mclk);
		while (o_ack !== 1'b1);
		q = o_rdata;
		err_q = o_err;
		@(posedge i_mclk);
		i_req <= 1'b0;
	endtask
	always @(posedge i_mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (10) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		apb(0, OFS_SYSCFG, 0, {28'h0, SYSCFG_RST}, 0);
		apb(0, OFS_BUSCFG, 0, {20'h0, BUSCFG0_RST}, 0);
		apb(0, OFS_RANGE, 0, 0, 0);
		apb(0, 8'hfc, 0, 0, 1);
		apb(1, OFS_BUSCFG, 32'hc80, 0, 0);
		cpu(1, 24'h000010, 16'h1234);
		cpu(0, 24'h000010, 0);
		cmp(q, 16'h1234);
		cmp(m.cs_r, 5'h1e);
		cmp(m.addr_r, 16'h0010);
		for (int i = 1; i <= 4; i++)
		begin
			apb(1, OFS_RANGE + 8'(4 * (i - 1)), 32'h100, 0, 0);
			apb(1, OFS_BUSCFG + 8'(4 * i), (i == 1) ? 32'he00 : 32'hd00, 0, 0);
			cpu(1, 24'h100004, 16'habcd);
			cpu(0, 24'h100004, 0);
			cmp(m.cs_r, 5'(~(5'h1 << i)));
			cmp(q, (i == 1) ? 16'h00cd : 16'habcd);
			cmp(m.addr_r[7:0], 8'h04);
		end
		cmp(o_addr_oe_n, 1'b0);
		for (int s = 0; s < 4; s++)
		begin
			apb(1, OFS_SYSCFG, 32'(1 + 4 * s), 0, 0);
			cpu(0, 24'h100004, 0);
			cmp(m.seg_r, segx[s]);
			cmp(o_seg_out, 8'h10 & ~segx[s]);
		end
		apb(0, OFS_STATUS, 0, 32'h78, 0);
		apb(1, OFS_SYSCFG, 32'h1, 0, 0);
		t0 = cyc;
		cpu(0, 24'h000010, 0);
		t0 = cyc - t0;
		slow <= 4'h8;
		t1 = cyc;
		cpu(0, 24'h000010, 0);
		t1 = cyc - t1;
		slow <= 4'h0;
		cmp(t1 >= t0 + 8, 1'b1);
		cmp(q, 16'h1234);
		apb(1, OFS_SYSCFG, 0, 0, 0);
		cpu(0, 24'h000010, 0);
		cmp(err_q, 1'b1);
		// Hold asserted early to prove it is ignored until enabled
		i_hold_n <= 1'b0;
		apb(1, OFS_SYSCFG, 32'h1, 0, 0);
		repeat (6) @(negedge i_mclk);
		cmp(o_bus_release_acknowledge_n, 1'b1);
		apb(1, OFS_SYSCFG, 32'h3, 0, 0);
		repeat (6) @(negedge i_mclk);
		cmp(o_bus_release_acknowledge_n, 1'b0);
		cmp(o_data_oe_n, 16'hffff);
		@(posedge i_mclk);
		i_hold_n <= 1'b1;
		repeat (6) @(negedge i_mclk);
		cmp(o_bus_release_acknowledge_n, 1'b1);
		cmp(o_bus_release_acknowledge_oe_n, 1'b0);
		apb(1, OFS_PINDIR, 32'h1, 0, 0);
		fork
			cpu(0, 24'h000010, 0);
			begin
				repeat (6) @(negedge i_mclk);
				cmp(o_bus_need_request_out_n, 1'b0);
				cmp(o_bus_release_acknowledge_oe_n, 1'b1);
				@(posedge i_mclk);
				bus_release_acknowledge_ext <= 1'b0;
			end
		join
		cmp(q, 16'h1234);
		wrap_up();
	end
endmodule
